// >>> common/line_supervisor_defs.svh
/*
  Register offsets, field positions, reset values and mode codes of the
  line supervisory block. Assumes a 32-bit AXI4-Lite bus with byte addresses.
*/
`ifndef LINE_SUPERVISOR_DEFS_SVH
`define LINE_SUPERVISOR_DEFS_SVH

`define ADDR_W            8
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_INT_STATUS    8'h08
`define OFS_INT_CLEAR     8'h0c
`define OFS_INT_ENABLE    8'h10
`define OFS_THERM_COUNT   8'h14

`define CTRL_OVERRIDE_BIT 0
`define CTRL_MODE_LSB     1
`define CTRL_BATTERY_BIT  4
`define CTRL_SWITCH_BIT   5
`define CTRL_RESET        6'h20

`define INT_W             4
`define INT_OVERHEAT_BIT  0
`define INT_COOLED_BIT    1
`define INT_MODE_BIT      2
`define INT_LOOPHIGH_BIT  3
`define INT_ENABLE_RESET  4'h0

`define MODE_LOOPBACK     3'h5
`define MODE_SHUTDOWN     3'h7

`define PIN_W             7
`define PIN_RESET         7'h41
`define COUNT_W           16

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// >>> common/line_supervisor_pkg.sv
/*
  Types shared by the line supervisory block.
  Assumes line_supervisor_defs.svh is on the include path.
*/
`include "line_supervisor_defs.svh"

package line_supervisor_pkg;

  typedef struct packed {
    logic [2:0] modeCode;
    logic       batteryChoice;
    logic       auxSwitchCtrlN;
  } lineCtrl_t;

  typedef struct packed {
    logic thermalAlarmN;
    logic hookStatusN;
    logic highBatterySupply;
    logic lowBatterySupply;
    logic tipAmpEn;
    logic ringAmpEn;
    logic loopbackTestMode;
    logic auxSwitchOn;
  } lineOut_t;

  typedef enum logic [1:0] {
    ACTIVE,
    HOT_SHUTDOWN,
    POWER_DENIAL
  } thermState_t;

endpackage

// >>> src/line_supervisor.sv
/*
  Supervisory logic of a ringing line interface: thermal shutdown cycling,
  power denial, battery selection, uncommitted switch control, with an
  AXI4-Lite register slave and a level interrupt.
  Assumes mclk at 250 MHz, rst asynchronous active high, and that every
  line pin arrives asynchronously and is synchronised here.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
// Behaviour
// RULE1 - Shutdown mode disables both line amplifiers
// RULE2 - Overheat: alarm low, hook high, shut down
// RULE3 - Cooled: alarm high, hook shows loop
// RULE4 - Repeated overheat repeats alarm and shutdown
// RULE5 - Shutdown mode holds shutdown, stops thermal cycling
// RULE6 - Battery choice high selects high battery
// RULE7 - Loopback mode meant for low battery only
// RULE8 - Battery decode independent of mode decode
// RULE9 - Controller changes battery with or before mode
// RULE10 - Controller uses low battery when off hook
// RULE11 - Controller uses high battery for compliant standby
// RULE12 - Switch on while its control is low
// RULE13 - Switch path separate from mode decode
// RULE14 - Code 111 selects shutdown, no supervision
// RULE15 - Code 101 selects loopback internal termination
// RULE16 - Controller drives three-bit mode code, MSB high; the controller model also drives codes with MSB low, such as 000
// RULE17 - Overheat is one level input, followed directly
`timescale 1ns/1ns
`include "line_supervisor_defs.svh"

module line_supervisor (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [2:0]           modeCode,
  input  wire logic                 batteryChoice,
  input  wire logic                 auxSwitchCtrlN,
  input  wire logic                 overTemp,
  input  wire logic                 loopDetectN,
  output logic                      thermalAlarmN,
  output logic                      hookStatusN,
  output logic                      highBatterySupply,
  output logic                      lowBatterySupply,
  output logic                      tipAmpEn,
  output logic                      ringAmpEn,
  output logic                      loopbackTestMode,
  output logic                      auxSwitchOn,
  output logic                      irq,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [`ADDR_W-1:0]   awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [`ADDR_W-1:0]   araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp
);

  function automatic logic isShutdown(input logic [2:0] code);
    isShutdown = (code == `MODE_SHUTDOWN); // RULE14
  endfunction

  function automatic logic isLoopback(input logic [2:0] code);
    isLoopback = (code == `MODE_LOOPBACK); // RULE15
  endfunction

  function automatic logic isMapped(input logic [`ADDR_W-1:0] addr);
    isMapped = (addr == `OFS_CTRL) || (addr == `OFS_STATUS) ||
               (addr == `OFS_INT_STATUS) || (addr == `OFS_INT_CLEAR) ||
               (addr == `OFS_INT_ENABLE) || (addr == `OFS_THERM_COUNT);
  endfunction

  // Synchronisers reset to idle pin levels, so no false hook or switch pulse follows reset.
  localparam logic [`PIN_W-1:0] pinIdle = `PIN_RESET;
  logic [`PIN_W-1:0] pinRaw;
  logic [`PIN_W-1:0] syncA_q;
  logic [`PIN_W-1:0] syncB_q;

  assign pinRaw = {loopDetectN, overTemp, modeCode, batteryChoice, auxSwitchCtrlN};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          syncA_q[gi] <= pinIdle[gi];
          syncB_q[gi] <= pinIdle[gi];
        end else if (ce) begin
          syncA_q[gi] <= pinRaw[gi];
          syncB_q[gi] <= syncA_q[gi];
        end
      end
    end
  endgenerate

  line_supervisor_pkg::lineCtrl_t pinCtrl;
  logic                           hotNow;
  logic                           loopNow;

  assign pinCtrl = syncB_q[4:0];
  assign hotNow  = syncB_q[5];
  assign loopNow = syncB_q[6];

  // Software control register; it may override the pins.
  logic [5:0] ctrl_q, ctrl_d;

  line_supervisor_pkg::lineCtrl_t effCtrl;

  always_comb begin
    if (ctrl_q[`CTRL_OVERRIDE_BIT]) begin
      effCtrl.modeCode       = ctrl_q[`CTRL_MODE_LSB +: 3];
      effCtrl.batteryChoice  = ctrl_q[`CTRL_BATTERY_BIT];
      effCtrl.auxSwitchCtrlN = ctrl_q[`CTRL_SWITCH_BIT];
    end else begin
      effCtrl = pinCtrl;
    end
  end

  // Thermal state machine.
  line_supervisor_pkg::thermState_t state_q,      state_d;
  logic                             hotPrev_q;
  logic [2:0]                       modePrev_q;
  logic                             loopHigh_q;
  logic [`COUNT_W-1:0]              thermCount_q, thermCount_d;
  logic                             loopHighNow;

  assign loopHighNow = isLoopback(effCtrl.modeCode) & effCtrl.batteryChoice;

  always_comb begin
    state_d      = state_q;
    thermCount_d = thermCount_q;
    case (state_q)
      line_supervisor_pkg::ACTIVE: begin
        if (isShutdown(effCtrl.modeCode)) begin
          state_d = line_supervisor_pkg::POWER_DENIAL; // RULE5
        end else if (hotNow) begin
          state_d = line_supervisor_pkg::HOT_SHUTDOWN; // RULE2 RULE4
        end
      end
      line_supervisor_pkg::HOT_SHUTDOWN: begin
        if (isShutdown(effCtrl.modeCode)) begin
          state_d = line_supervisor_pkg::POWER_DENIAL; // RULE5
        end else if (!hotNow) begin
          state_d = line_supervisor_pkg::ACTIVE; // RULE3
        end
      end
      line_supervisor_pkg::POWER_DENIAL: begin
        // No recovery cycling here; leaving needs a different mode code.
        if (!isShutdown(effCtrl.modeCode)) begin
          state_d = hotNow ? line_supervisor_pkg::HOT_SHUTDOWN
                           : line_supervisor_pkg::ACTIVE;
        end
      end
      default: begin
        state_d = line_supervisor_pkg::POWER_DENIAL;
      end
    endcase
    if (state_d == line_supervisor_pkg::HOT_SHUTDOWN &&
        state_q != line_supervisor_pkg::HOT_SHUTDOWN &&
        thermCount_q != {`COUNT_W{1'b1}}) begin
      thermCount_d = thermCount_q + `COUNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q      <= line_supervisor_pkg::ACTIVE;
      hotPrev_q    <= 1'b0;
      modePrev_q   <= 3'h0;
      loopHigh_q   <= 1'b0;
      thermCount_q <= `COUNT_W'(0);
    end else if (ce) begin
      state_q      <= state_d;
      hotPrev_q    <= hotNow;
      modePrev_q   <= effCtrl.modeCode;
      loopHigh_q   <= loopHighNow;
      thermCount_q <= thermCount_d;
    end
  end

  // Line outputs, registered from the next state so that they agree with it.
  line_supervisor_pkg::lineOut_t out_q, out_d;
  logic                          shutNext;

  assign shutNext = (state_d != line_supervisor_pkg::ACTIVE);

  always_comb begin
    out_d.thermalAlarmN     = !hotNow; // RULE2 RULE3 RULE17
    out_d.hookStatusN       = shutNext ? 1'b1 : loopNow; // RULE2 RULE3 RULE14
    out_d.highBatterySupply = effCtrl.batteryChoice; // RULE6 RULE8
    out_d.lowBatterySupply  = !effCtrl.batteryChoice; // RULE6 RULE8
    out_d.tipAmpEn          = !shutNext; // RULE1 RULE5
    out_d.ringAmpEn         = !shutNext; // RULE1 RULE5
    out_d.loopbackTestMode  = !shutNext && isLoopback(effCtrl.modeCode); // RULE15
    out_d.auxSwitchOn       = !effCtrl.auxSwitchCtrlN; // RULE12 RULE13
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q <= '{thermalAlarmN: 1'b1, hookStatusN: 1'b1, highBatterySupply: 1'b0,
                 lowBatterySupply: 1'b1, tipAmpEn: 1'b0, ringAmpEn: 1'b0,
                 loopbackTestMode: 1'b0, auxSwitchOn: 1'b0};
    end else if (ce) begin
      out_q <= out_d;
    end
  end

  assign {thermalAlarmN, hookStatusN, highBatterySupply, lowBatterySupply,
          tipAmpEn, ringAmpEn, loopbackTestMode, auxSwitchOn} = out_q;

  // Interrupt events. A high battery in loopback is still connected, but
  // flagged, since the internal termination is sized for the low battery.
  logic [`INT_W-1:0] events;

  always_comb begin
    events                    = '0;
    events[`INT_OVERHEAT_BIT] = hotNow && !hotPrev_q;
    events[`INT_COOLED_BIT]   = !hotNow && hotPrev_q;
    events[`INT_MODE_BIT]     = effCtrl.modeCode != modePrev_q;
    events[`INT_LOOPHIGH_BIT] = loopHighNow && !loopHigh_q; // RULE7
  end

  // AXI4-Lite slave. Address and data are taken in either order.
  logic               awHeld_q,    awHeld_d;
  logic [`ADDR_W-1:0] awAddr_q,    awAddr_d;
  logic               wHeld_q,     wHeld_d;
  logic [31:0]        wData_q,     wData_d;
  logic [3:0]         wStrb_q,     wStrb_d;
  logic               awReady_q,   awReady_d;
  logic               wReady_q,    wReady_d;
  logic               bValid_q,    bValid_d;
  logic [1:0]         bResp_q,     bResp_d;
  logic               arReady_q,   arReady_d;
  logic               rValid_q,    rValid_d;
  logic [31:0]        rData_q,     rData_d;
  logic [1:0]         rResp_q,     rResp_d;
  logic [`INT_W-1:0]  intStatus_q, intStatus_d;
  logic [`INT_W-1:0]  intEnable_q, intEnable_d;
  logic               irq_q,       irq_d;
  logic               doWrite;
  logic [31:0]        statusWord;

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;

  assign statusWord = {21'h0, out_q.hookStatusN, out_q.thermalAlarmN, state_q, loopNow,
                       hotNow, effCtrl.auxSwitchCtrlN, effCtrl.batteryChoice, effCtrl.modeCode};

  always_comb begin
    awHeld_d    = awHeld_q;
    awAddr_d    = awAddr_q;
    wHeld_d     = wHeld_q;
    wData_d     = wData_q;
    wStrb_d     = wStrb_q;
    bValid_d    = bValid_q;
    bResp_d     = bResp_q;
    ctrl_d      = ctrl_q;
    intEnable_d = intEnable_q;
    intStatus_d = intStatus_q;
    if (awvalid && awReady_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wReady_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (bValid_q && bready) begin
      bValid_d = 1'b0;
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = isMapped(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      if (awAddr_q == `OFS_CTRL && wStrb_q[0]) begin
        ctrl_d = wData_q[5:0];
      end
      if (awAddr_q == `OFS_INT_ENABLE && wStrb_q[0]) begin
        intEnable_d = wData_q[`INT_W-1:0];
      end
      if (awAddr_q == `OFS_INT_CLEAR && wStrb_q[0]) begin
        intStatus_d = intStatus_q & ~wData_q[`INT_W-1:0];
      end
    end
    // A new event beats a clear in the same cycle.
    intStatus_d = intStatus_d | events;
    awReady_d   = !awHeld_d && !bValid_d;
    wReady_d    = !wHeld_d && !bValid_d;
    irq_d       = |(intStatus_d & intEnable_d);
  end

  always_comb begin
    arReady_d = !rValid_q;
    rValid_d  = rValid_q;
    rData_d   = rData_q;
    rResp_d   = rResp_q;
    if (rValid_q && rready) begin
      rValid_d  = 1'b0;
      arReady_d = 1'b1;
    end
    if (arvalid && arReady_q) begin
      arReady_d = 1'b0;
      rValid_d  = 1'b1;
      rResp_d   = isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr)
        `OFS_CTRL:        rData_d = {26'h0, ctrl_q};
        `OFS_STATUS:      rData_d = statusWord;
        `OFS_INT_STATUS:  rData_d = {28'h0, intStatus_q};
        `OFS_INT_ENABLE:  rData_d = {28'h0, intEnable_q};
        `OFS_THERM_COUNT: rData_d = {16'h0, thermCount_q};
        default:          rData_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_q    <= 1'b0;
      awAddr_q    <= '0;
      wHeld_q     <= 1'b0;
      wData_q     <= 32'h0;
      wStrb_q     <= 4'h0;
      awReady_q   <= 1'b0;
      wReady_q    <= 1'b0;
      bValid_q    <= 1'b0;
      bResp_q     <= `RESP_OKAY;
      arReady_q   <= 1'b0;
      rValid_q    <= 1'b0;
      rData_q     <= 32'h0;
      rResp_q     <= `RESP_OKAY;
      ctrl_q      <= `CTRL_RESET;
      intStatus_q <= '0;
      intEnable_q <= `INT_ENABLE_RESET;
      irq_q       <= 1'b0;
    end else if (ce) begin
      awHeld_q    <= awHeld_d;
      awAddr_q    <= awAddr_d;
      wHeld_q     <= wHeld_d;
      wData_q     <= wData_d;
      wStrb_q     <= wStrb_d;
      awReady_q   <= awReady_d;
      wReady_q    <= wReady_d;
      bValid_q    <= bValid_d;
      bResp_q     <= bResp_d;
      arReady_q   <= arReady_d;
      rValid_q    <= rValid_d;
      rData_q     <= rData_d;
      rResp_q     <= rResp_d;
      ctrl_q      <= ctrl_d;
      intStatus_q <= intStatus_d;
      intEnable_q <= intEnable_d;
      irq_q       <= irq_d;
    end
  end

  assign {awready, wready, bvalid, bresp} = {awReady_q, wReady_q, bValid_q, bResp_q};
  assign {arready, rvalid, rdata, rresp}  = {arReady_q, rValid_q, rData_q, rResp_q};
  assign irq = irq_q;

endmodule

// >>> test/line_supervisor_assertions.sv
/*
  Checker for the line pins of line_supervisor.
  Assumes the control override bit stays clear, so the pins rule the outputs.
*/
`timescale 1ns/1ns
module line_supervisor_assertions (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [2:0] modeCode,
  input wire logic       batteryChoice,
  input wire logic       auxSwitchCtrlN,
  input wire logic       overTemp,
  input wire logic       loopDetectN,
  input wire logic       thermalAlarmN,
  input wire logic       hookStatusN,
  input wire logic       highBatterySupply,
  input wire logic       lowBatterySupply,
  input wire logic       tipAmpEn,
  input wire logic       ringAmpEn,
  input wire logic       loopbackTestMode,
  input wire logic       auxSwitchOn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Three enabled edges cover both synchroniser stages and the output flop.
  AST_ALARM_LOW: assert property ((ce && overTemp)[*3] |=> !thermalAlarmN)
    else $error("alarm not low while hot");
  AST_HOT_SAFE: assert property ((ce && overTemp)[*3] |=>
    hookStatusN && !tipAmpEn && !ringAmpEn)
    else $error("hook or amplifiers wrong while hot");
  AST_COOL: assert property ((ce && !overTemp && modeCode != 3'h7)[*3] |=>
    thermalAlarmN && hookStatusN == $past(loopDetectN, 3))
    else $error("alarm or hook wrong after cooling");
  AST_DENIAL: assert property ((ce && modeCode == 3'h7)[*3] |=>
    !tipAmpEn && !ringAmpEn && hookStatusN && !loopbackTestMode)
    else $error("shutdown mode not shut down");
  AST_LOOPBACK: assert property ((ce && modeCode == 3'h5 && !overTemp)[*3] |=>
    loopbackTestMode && tipAmpEn && ringAmpEn)
    else $error("loopback not active");
  AST_BATT_HIGH: assert property ((ce && batteryChoice)[*3] |=>
    highBatterySupply && !lowBatterySupply)
    else $error("high battery not connected");
  AST_BATT_LOW: assert property ((ce && !batteryChoice)[*3] |=>
    lowBatterySupply && !highBatterySupply)
    else $error("low battery not connected");
  AST_SW_ON: assert property ((ce && !auxSwitchCtrlN)[*3] |=> auxSwitchOn)
    else $error("switch not on");
  AST_SW_OFF: assert property ((ce && auxSwitchCtrlN)[*3] |=> !auxSwitchOn)
    else $error("switch not off");
endmodule

bind line_supervisor line_supervisor_assertions chk_i (.*);

// >>> test/line_controller_model.sv
/*
  Behavioural system controller driving the mode, battery and switch pins.
  Assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/1ns
module line_controller_model (
  input wire logic  mclk,
  output logic [2:0] modeCode,
  output logic       batteryChoice,
  output logic       auxSwitchCtrlN
);
  initial begin
    modeCode = 3'h0;
    batteryChoice = 1'h0;
    auxSwitchCtrlN = 1'h1;
  end
  function automatic logic pick_battery(input logic offHook, input logic mtu);
    return !offHook && mtu;
  endfunction
  // The battery moves one edge ahead of the code, so the detector glitches only when loopback is left for the high battery.
  task automatic go(input logic [2:0] m, input logic b);
    @(posedge mclk);
    batteryChoice <= b;
    @(posedge mclk);
    modeCode <= m;
  endtask
  task automatic set_switch(input logic on);
    @(posedge mclk);
    auxSwitchCtrlN <= !on;
  endtask
endmodule

// >>> test/tb_top.sv
/*
  Self-checking bench for line_supervisor.
  Assumes the checker binds itself and the controller model owns the mode pins.
*/
`timescale 1ns/1ns
`include "line_supervisor_defs.svh"
module tb_top;
  logic              mclk, rst, ce, overTemp, loopDetectN;
  logic [2:0]        modeCode;
  logic              batteryChoice, auxSwitchCtrlN, irq;
  logic              thermalAlarmN, hookStatusN, highBatterySupply, lowBatterySupply;
  logic              tipAmpEn, ringAmpEn, loopbackTestMode, auxSwitchOn;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rs;
  int                n_mismatch, cmp_count, cycles;

  line_supervisor DUT (.*);
  line_controller_model ctl (.*);

  initial mclk = 1'h0;
  always #2 mclk = ~mclk;

  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge mclk);
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    while (!bvalid) @(posedge mclk);
    bready <= 1'h0;
    chk(bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge mclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    axi_rd(a);
    chk(rd, ed);
    chk(rs, er);
  endtask

  task automatic t_reset();
    chk({thermalAlarmN, hookStatusN, highBatterySupply, lowBatterySupply, tipAmpEn,
         auxSwitchOn, irq}, 7'h68);
    rst <= 1'h0;
    wt(5);
    rdc(`OFS_CTRL, 32'h20, 2'h0);
    wr(`OFS_CTRL, 32'hffff_ffde, 2'h0);
    rdc(`OFS_CTRL, 32'h1e, 2'h0);
    wr(`OFS_CTRL, 32'h20, 2'h0);
    rdc(`OFS_INT_ENABLE, 32'h0, 2'h0);
    rdc(`OFS_INT_CLEAR, 32'h0, 2'h0);
    rdc(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'hffff_ffff, 2'h2);
    $display("test reset done");
  endtask

  task automatic t_thermal();
    wr(`OFS_INT_ENABLE, 32'h3, 2'h0);
    wr(`OFS_INT_CLEAR, 32'hf, 2'h0);
    loopDetectN <= 1'h0;
    wt(5);
    for (int i = 0; i < 2; i++) begin
      overTemp <= 1'h1;
      wt(5);
      chk({thermalAlarmN, hookStatusN, tipAmpEn, ringAmpEn}, 4'h4);
      chk(irq, 1'h1);
      overTemp <= 1'h0;
      wt(5);
      chk({thermalAlarmN, hookStatusN, tipAmpEn, ringAmpEn}, 4'hb);
    end
    rdc(`OFS_INT_STATUS, 32'h3, 2'h0);
    rdc(`OFS_THERM_COUNT, 32'h2, 2'h0);
    wr(`OFS_INT_CLEAR, 32'h1, 2'h0);
    rdc(`OFS_INT_STATUS, 32'h2, 2'h0);
    chk(irq, 1'h1);
    wr(`OFS_INT_ENABLE, 32'h1, 2'h0);
    wt(2);
    chk(irq, 1'h0);
    wr(`OFS_INT_CLEAR, 32'hf, 2'h0);
    $display("test thermal done");
  endtask

  task automatic t_denial();
    overTemp <= 1'h1;
    wt(5);
    ctl.go(3'h7, 1'h1);
    wt(5);
    overTemp <= 1'h0;
    wt(5);
    chk({thermalAlarmN, hookStatusN, tipAmpEn, ringAmpEn, loopbackTestMode},
        5'h18);
    overTemp <= 1'h1;
    wt(5);
    overTemp <= 1'h0;
    wt(5);
    chk({hookStatusN, tipAmpEn, ringAmpEn}, 3'h4);
    rdc(`OFS_THERM_COUNT, 32'h3, 2'h0);
    ctl.go(3'h0, ctl.pick_battery(1'h1, 1'h0));
    wt(5);
    chk({hookStatusN, tipAmpEn, ringAmpEn}, 3'h3);
    loopDetectN <= 1'h1;
    $display("test denial done");
  endtask

  task automatic t_sweep();
    wr(`OFS_INT_CLEAR, 32'hf, 2'h0);
    for (int m = 0; m < 8; m++) begin
      for (int b = 1; b >= 0; b--) begin
        ctl.go(m[2:0], b[0]);
        wt(5);
        chk({highBatterySupply, lowBatterySupply}, {b[0], !b[0]});
        chk(loopbackTestMode, m == 5);
      end
    end
    axi_rd(`OFS_INT_STATUS);
    chk(rd[3], 1'h1);
    ctl.go(3'h0, ctl.pick_battery(1'h0, 1'h1));
    $display("test battery done");
  endtask

  task automatic t_switch();
    for (int m = 0; m < 8; m++) begin
      ctl.go(m[2:0], 1'h0);
      for (int s = 1; s >= 0; s--) begin
        ctl.set_switch(s[0]);
        wt(5);
        chk(auxSwitchOn, s[0]);
        chk(loopbackTestMode, m == 5);
      end
    end
    ce <= 1'h0;
    ctl.set_switch(1'h1);
    wt(5);
    chk(auxSwitchOn, 1'h0);
    ce <= 1'h1;
    wt(5);
    chk(auxSwitchOn, 1'h1);
    $display("test switch done");
  endtask

  initial begin
    rst = 1'h1;
    ce = 1'h1;
    overTemp = 1'h0;
    loopDetectN = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    wt(2);
    t_reset();
    t_thermal();
    t_denial();
    t_sweep();
    t_switch();
    complete_run();
  end
endmodule
